/* logic/urx_serial.sv */
/*
 * Asynchronous serial block: baud generation, receiver with error flags,
 * mute and wake-up, parity, transmitter flags and the shared interrupt.
 * Assumes the serial input is synchronous to i_clock and that the register
 * bus is an Avalon-MM master keeping each request until waitrequest is low.
 */
`timescale 1ns/1ps
`include "urx_defs.svh"

module urx_serial (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire urx_pkg::urx_avs_s i_avs,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_serial_in_pin,
	output logic o_tx_pin,
	output logic o_tx_oe,
	input wire logic i_cpu_irq_mask,
	input wire logic i_halt,
	output logic o_irq
);
	import urx_pkg::*;

	urx_state_s r;
	urx_state_s n;
	logic req, acc, wr0, rd, hit_s, hit_d, hit_b, hit_1, hit_2;
	logic clr_rx, clr_tx, run, pre_tick, tx_tick, rx_tick;
	logic rx_done, idle_ev, maj, noisy, msb, perr, take, m, pin;
	logic [3:0] pre_m1, nbits, flen;
	logic [6:0] tx_m1, rx_m1;
	logic [7:0] idle_need, rmux;
	logic [2:0] v;
	logic [8:0] word, txw;
	logic [10:0] frame;

	// --------------------------------------------------------------
	// Bus decode
	// --------------------------------------------------------------
	assign req = i_avs.read | i_avs.write;
	assign acc = req & r.ack & ~i_halt;
	assign wr0 = i_avs.write & acc & i_avs.byteenable[0];
	assign rd = i_avs.read & acc;
	assign hit_s = i_avs.address == `URX_OFS_STATUS;
	assign hit_d = i_avs.address == `URX_OFS_DATA;
	assign hit_b = i_avs.address == `URX_OFS_BAUD;
	assign hit_1 = i_avs.address == `URX_OFS_CTRL1;
	assign hit_2 = i_avs.address == `URX_OFS_CTRL2;
	assign clr_rx = rd & hit_d & r.stat_seen;
	assign clr_tx = wr0 & hit_d & r.stat_seen;
	assign o_avs_waitrequest = req & (~r.ack | i_halt);
	assign o_avs_readdata = {24'h000000, r.rdata};
	assign rmux = hit_s ? r.status :
		hit_d ? r.rx_hold[7:0] :
		hit_b ? r.baud :
		hit_1 ? {r.rx_hold[8], r.ctrl1[6:0]} :
		hit_2 ? r.ctrl2 : 8'h00;

	// --------------------------------------------------------------
	// Baud ticks
	// --------------------------------------------------------------
	assign run = ~r.ctrl1[`URX_C1_OFF];
	assign pre_m1 = (r.baud[`URX_BR_PRE] == 2'h0) ? `URX_PRE_M1_0 :
		(r.baud[`URX_BR_PRE] == 2'h1) ? `URX_PRE_M1_1 :
		(r.baud[`URX_BR_PRE] == 2'h2) ? `URX_PRE_M1_2 : `URX_PRE_M1_3;
	assign tx_m1 = 7'((8'h01 << r.baud[`URX_BR_TX]) - 8'h01);
	assign rx_m1 = 7'((8'h01 << r.baud[`URX_BR_RX]) - 8'h01);
	assign pre_tick = run & (r.pre_cnt == pre_m1);
	assign tx_tick = pre_tick & (r.txd_cnt == tx_m1);
	assign rx_tick = pre_tick & (r.rxd_cnt == rx_m1);

	// --------------------------------------------------------------
	// Frame formats and parity
	// --------------------------------------------------------------
	assign m = r.ctrl1[`URX_C1_LONG];
	assign nbits = m ? `URX_BITS_LONG : `URX_BITS_SHORT;
	assign flen = m ? `URX_FRAME_LONG : `URX_FRAME_SHORT;
	assign idle_need = m ? `URX_IDLE_LONG : `URX_IDLE_SHORT;
	assign pin = i_serial_in_pin;
	assign v = {r.rx_samp, pin};
	assign maj = (v[2] & v[1]) | (v[2] & v[0]) | (v[1] & v[0]);
	assign noisy = (v[2] != v[1]) | (v[1] != v[0]);
	assign word = m ? r.rx_sh : {1'b0, r.rx_sh[8:1]};
	assign msb = r.rx_sh[8];
	assign perr = r.ctrl1[`URX_C1_PCE] &
		((m ? ^r.rx_sh : ^r.rx_sh[8:1]) != r.ctrl1[`URX_C1_PS]);
	always_comb begin
		txw = r.tx_hold;
		if (r.ctrl1[`URX_C1_PCE]) begin
			if (m) begin
				txw[8] = ^r.tx_hold[7:0] ^ r.ctrl1[`URX_C1_PS];
			end else begin
				txw[7] = ^r.tx_hold[6:0] ^ r.ctrl1[`URX_C1_PS];
			end
		end
		frame = m ? {1'b1, txw, 1'b0} : {2'b11, txw[7:0], 1'b0};
	end

	// --------------------------------------------------------------
	// Next state
	// --------------------------------------------------------------
	always_comb begin
		n = r;
		n.ack = 1'b0;
		rx_done = 1'b0;
		idle_ev = 1'b0;
		take = 1'b0;
		if (req & ~r.ack) begin
			n.ack = 1'b1;
			n.rdata = rmux;
		end
		if (acc & hit_s) begin
			n.stat_seen = 1'b1;
		end else if (acc & hit_d) begin
			n.stat_seen = 1'b0;
		end
		if (clr_rx) begin
			n.status[5:0] = 6'h00;
		end
		if (clr_tx) begin
			n.status[7:6] = 2'h0;
		end
		if (wr0 & hit_d) begin
			n.tx_hold = {r.ctrl1[`URX_C1_T8], i_avs.writedata[7:0]};
			n.tx_full = 1'b1;
		end
		if (wr0 & hit_b) begin
			n.baud = i_avs.writedata[7:0];
		end
		if (wr0 & hit_1) begin
			n.ctrl1 = {1'b0, i_avs.writedata[6:0]};
		end
		if (wr0 & hit_2) begin
			n.ctrl2 = i_avs.writedata[7:0];
		end

		n.pre_cnt = (~run | pre_tick) ? 4'h0 : r.pre_cnt + 4'h1;
		if (~run | tx_tick) begin
			n.txd_cnt = 7'h00;
		end else if (pre_tick) begin
			n.txd_cnt = r.txd_cnt + 7'h01;
		end
		if (~run | rx_tick) begin
			n.rxd_cnt = 7'h00;
		end else if (pre_tick) begin
			n.rxd_cnt = r.rxd_cnt + 7'h01;
		end
		// A new rate restarts the dividers so no count overshoots its end.
		if (wr0 & hit_b) begin
			n.pre_cnt = 4'h0;
			n.txd_cnt = 7'h00;
			n.rxd_cnt = 7'h00;
		end

		// Receiver, sixteen ticks per bit.
		if (~r.ctrl2[`URX_C2_RE]) begin
			n.rx_st = RX_IDLE;
			n.idle_cnt = 8'h00;
		end else if (rx_tick) begin
			unique case (r.rx_st)
			RX_IDLE: begin
				if (!pin) begin
					n.rx_st = RX_START;
					n.rx_ph = 4'h0;
					n.rx_noise = 1'b0;
					n.idle_cnt = 8'h00;
				end else if (r.idle_cnt != idle_need) begin
					n.idle_cnt = r.idle_cnt + 8'h01;
					idle_ev = (n.idle_cnt == idle_need);
				end
			end
			default: begin
				n.rx_ph = r.rx_ph + 4'h1;
				if (r.rx_ph == `URX_PH_S1 || r.rx_ph == `URX_PH_S2) begin
					n.rx_samp = {r.rx_samp[0], pin};
				end
				if (r.rx_ph == `URX_PH_MID) begin
					n.rx_noise = r.rx_noise | noisy;
					if (r.rx_st == RX_START && maj) begin
						n.rx_st = RX_IDLE;
					end else if (r.rx_st == RX_DATA) begin
						n.rx_sh = {maj, r.rx_sh[8:1]};
						n.rx_cnt = r.rx_cnt + 4'h1;
					end else if (r.rx_st == RX_STOP) begin
						rx_done = 1'b1;
						n.rx_st = RX_IDLE;
					end
				end
				if (r.rx_ph == `URX_PH_LAST) begin
					if (r.rx_st == RX_START) begin
						n.rx_st = RX_DATA;
						n.rx_cnt = 4'h0;
					end else if (r.rx_st == RX_DATA &&
						r.rx_cnt == nbits) begin
						n.rx_st = RX_STOP;
					end
				end
			end
			endcase
		end

		// Completed frame: flags and holding register.
		if (rx_done) begin
			take = ~r.ctrl2[`URX_C2_MUTE] |
				(r.ctrl1[`URX_C1_WAKE] & msb);
			if (r.ctrl2[`URX_C2_MUTE] & r.ctrl1[`URX_C1_WAKE] & msb) begin
				n.ctrl2[`URX_C2_MUTE] = 1'b0;
			end
			if (take) begin
				if (n.status[`URX_ST_RECEIVE_FULL_FLAG]) begin
					n.status[`URX_ST_OR] = 1'b1;
				end else begin
					n.rx_hold = word;
					n.status[`URX_ST_RECEIVE_FULL_FLAG] = 1'b1;
					n.idle_arm = 1'b1;
					if (r.rx_noise | noisy) begin
						n.status[`URX_ST_NF] = 1'b1;
					end
					if (~maj) begin
						n.status[`URX_ST_FE] = 1'b1;
					end
					if (perr) begin
						n.status[`URX_ST_PE] = 1'b1;
					end
				end
			end
		end
		if (idle_ev) begin
			if (r.ctrl2[`URX_C2_MUTE]) begin
				if (~r.ctrl1[`URX_C1_WAKE]) begin
					n.ctrl2[`URX_C2_MUTE] = 1'b0;
				end
			end else if (r.idle_arm) begin
				n.status[`URX_ST_IDLE] = 1'b1;
				n.idle_arm = 1'b0;
			end
		end

		// Transmitter.
		n.te_d = r.ctrl2[`URX_C2_TE];
		if (r.ctrl2[`URX_C2_TE] & ~r.te_d) begin
			n.pre_pend = 1'b1;
		end
		if (~r.ctrl2[`URX_C2_TE]) begin
			n.tx_full = 1'b0;
		end
		if (r.tx_st == TX_IDLE) begin
			n.tx_ph = 4'h0;
			n.tx_tc = 1'b1;
			n.tx_left = flen;
			n.tx_st = TX_SHIFT;
			if (~r.ctrl2[`URX_C2_TE]) begin
				n.tx_st = TX_IDLE;
				n.tx_line = 1'b1;
			end else if (r.pre_pend) begin
				n.tx_sh = 11'h7ff;
				n.tx_line = 1'b1;
				n.pre_pend = 1'b0;
			end else if (r.ctrl2[`URX_C2_SBK]) begin
				n.tx_sh = 11'h000;
				n.tx_line = 1'b0;
				n.brk_end = 1'b1;
			end else if (r.tx_full & ~n.status[`URX_ST_TRANSMIT_EMPTY_FLAG]) begin
				n.tx_sh = frame;
				n.tx_line = frame[0];
				n.tx_full = 1'b0;
				n.status[`URX_ST_TRANSMIT_EMPTY_FLAG] = 1'b1;
			end else if (r.brk_end) begin
				n.tx_sh = 11'h7ff;
				n.tx_line = 1'b1;
				n.tx_left = 4'h1;
				n.tx_tc = 1'b0;
				n.brk_end = 1'b0;
			end else begin
				n.tx_st = TX_IDLE;
				n.tx_line = 1'b1;
			end
		end else if (tx_tick) begin
			n.tx_ph = r.tx_ph + 4'h1;
			if (r.tx_ph == `URX_PH_LAST) begin
				if (r.tx_left == 4'h1) begin
					n.tx_st = TX_IDLE;
					if (r.tx_tc) begin
						n.status[`URX_ST_TC] = 1'b1;
					end
				end else begin
					n.tx_left = r.tx_left - 4'h1;
					n.tx_sh = {1'b1, r.tx_sh[10:1]};
					n.tx_line = r.tx_sh[1];
				end
			end
		end

		n.irq = ~i_cpu_irq_mask & (
			(n.ctrl2[`URX_C2_TIE] & n.status[`URX_ST_TRANSMIT_EMPTY_FLAG]) |
			(n.ctrl2[`URX_C2_TRANSMIT_DONE_IRQ_ENABLE] & n.status[`URX_ST_TC]) |
			(~n.ctrl2[`URX_C2_MUTE] & (
			(n.ctrl2[`URX_C2_RIE] &
			(n.status[`URX_ST_RECEIVE_FULL_FLAG] | n.status[`URX_ST_OR])) |
			(n.ctrl2[`URX_C2_IDLE_IRQ_ENABLE] & n.status[`URX_ST_IDLE]) |
			(n.ctrl1[`URX_C1_PIE] & n.status[`URX_ST_PE]))));

		if (i_halt) begin
			n = r;
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			r <= '0;
			r.status <= `URX_STATUS_RESET;
			r.tx_line <= `URX_TX_LINE_RESET;
		end else begin
			r <= n;
		end
	end

	assign o_tx_pin = r.tx_line;
	assign o_tx_oe = r.ctrl2[`URX_C2_TE] | r.ctrl2[`URX_C2_RE];
	assign o_irq = r.irq;

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	a_flag_clear: assert property (@(posedge i_clock) disable iff (!i_resetn)
		$fell(r.status[`URX_ST_OR]) |-> $past(clr_rx))
		else $error("overrun flag cleared without sequence");
	a_overrun_hold: assert property (@(posedge i_clock) disable iff (!i_resetn)
		$rose(r.status[`URX_ST_OR]) |-> $stable(r.rx_hold))
		else $error("holding register changed on overrun");
	a_mute_quiet: assert property (@(posedge i_clock) disable iff (!i_resetn)
		$past(r.ctrl2[`URX_C2_MUTE]) && r.ctrl2[`URX_C2_MUTE] |->
		!$rose(r.status[`URX_ST_RECEIVE_FULL_FLAG]) && !$rose(r.status[`URX_ST_IDLE]))
		else $error("receive flag set while muted");
	a_idle_wake: assert property (@(posedge i_clock) disable iff (!i_resetn)
		$fell(r.ctrl2[`URX_C2_MUTE]) && !r.ctrl1[`URX_C1_WAKE] |->
		!$rose(r.status[`URX_ST_IDLE]))
		else $error("idle flag set on idle wake");
	a_irq_mask: assert property (@(posedge i_clock) disable iff (!i_resetn)
		i_cpu_irq_mask |=> !o_irq)
		else $error("interrupt raised while masked");
	a_empty_set: assert property (@(posedge i_clock) disable iff (!i_resetn)
		$rose(r.status[`URX_ST_TRANSMIT_EMPTY_FLAG]) |->
		$past(r.tx_full) && r.tx_st == TX_SHIFT && !r.tx_full)
		else $error("transmit empty set without load");
	a_done_set: assert property (@(posedge i_clock) disable iff (!i_resetn)
		$rose(r.status[`URX_ST_TC]) |->
		$past(r.tx_st == TX_SHIFT) && r.tx_st == TX_IDLE)
		else $error("transmit done set outside frame end");
	a_idle_arm: assert property (@(posedge i_clock) disable iff (!i_resetn)
		$rose(r.status[`URX_ST_IDLE]) |-> $past(r.idle_arm) && !r.idle_arm)
		else $error("idle flag set twice without data");
	a_pre_bound: assert property (@(posedge i_clock) disable iff (!i_resetn)
		run && $stable(r.baud) |-> r.pre_cnt <= pre_m1)
		else $error("prescale counter out of range");
	a_div_bound: assert property (@(posedge i_clock) disable iff (!i_resetn)
		$stable(r.baud) && $past(run) |-> r.rxd_cnt <= rx_m1 && r.txd_cnt <= tx_m1)
		else $error("bit rate divider out of range");
	a_halt_freeze: assert property (@(posedge i_clock) disable iff (!i_resetn)
		$past(i_halt) |-> r == $past(r))
		else $error("state moved during halt");
	a_rx_full: assert property (@(posedge i_clock) disable iff (!i_resetn)
		$rose(r.status[`URX_ST_RECEIVE_FULL_FLAG]) |-> $past(r.rx_st == RX_STOP))
		else $error("receive full set outside frame end");
endmodule

/* shared/urx_defs.svh */
/*
 * Register offsets, field positions, reset values and timing counts of the
 * serial receive/transmit block.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses.
 */
`ifndef URX_DEFS_SVH
`define URX_DEFS_SVH

`define URX_OFS_STATUS 8'h00
`define URX_OFS_DATA 8'h04
`define URX_OFS_BAUD 8'h08
`define URX_OFS_CTRL1 8'h0c
`define URX_OFS_CTRL2 8'h10

`define URX_STATUS_RESET 8'hc0
`define URX_TX_LINE_RESET 1'b1

`define URX_ST_TRANSMIT_EMPTY_FLAG 7
`define URX_ST_TC 6
`define URX_ST_RECEIVE_FULL_FLAG 5
`define URX_ST_IDLE 4
`define URX_ST_OR 3
`define URX_ST_NF 2
`define URX_ST_FE 1
`define URX_ST_PE 0

`define URX_C1_T8 6
`define URX_C1_OFF 5
`define URX_C1_LONG 4
`define URX_C1_WAKE 3
`define URX_C1_PCE 2
`define URX_C1_PS 1
`define URX_C1_PIE 0

`define URX_C2_TIE 7
`define URX_C2_TRANSMIT_DONE_IRQ_ENABLE 6
`define URX_C2_RIE 5
`define URX_C2_IDLE_IRQ_ENABLE 4
`define URX_C2_TE 3
`define URX_C2_RE 2
`define URX_C2_MUTE 1
`define URX_C2_SBK 0

`define URX_BR_PRE 7:6
`define URX_BR_TX 5:3
`define URX_BR_RX 2:0

`define URX_PRE_M1_0 4'h0
`define URX_PRE_M1_1 4'h2
`define URX_PRE_M1_2 4'h3
`define URX_PRE_M1_3 4'hc

`define URX_PH_S1 4'h7
`define URX_PH_S2 4'h8
`define URX_PH_MID 4'h9
`define URX_PH_LAST 4'hf
`define URX_BITS_SHORT 4'h8
`define URX_BITS_LONG 4'h9
`define URX_FRAME_SHORT 4'ha
`define URX_FRAME_LONG 4'hb
`define URX_IDLE_SHORT 8'ha0
`define URX_IDLE_LONG 8'hb0

`endif

/* shared/urx_pkg.sv */
/*
 * Types of the serial receive/transmit block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package urx_pkg;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} urx_rx_e;
	typedef enum logic {TX_IDLE, TX_SHIFT} urx_tx_e;

	typedef struct packed {
		logic [7:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} urx_avs_s;

	typedef struct packed {
		logic [7:0] status;
		logic [7:0] ctrl1;
		logic [7:0] ctrl2;
		logic [7:0] baud;
		logic stat_seen;
		logic ack;
		logic [7:0] rdata;
		logic [3:0] pre_cnt;
		logic [6:0] txd_cnt;
		logic [6:0] rxd_cnt;
		urx_rx_e rx_st;
		logic [3:0] rx_ph;
		logic [3:0] rx_cnt;
		logic [1:0] rx_samp;
		logic rx_noise;
		logic [8:0] rx_sh;
		logic [8:0] rx_hold;
		logic [7:0] idle_cnt;
		logic idle_arm;
		urx_tx_e tx_st;
		logic [3:0] tx_ph;
		logic [3:0] tx_left;
		logic [10:0] tx_sh;
		logic tx_line;
		logic tx_tc;
		logic brk_end;
		logic pre_pend;
		logic te_d;
		logic [8:0] tx_hold;
		logic tx_full;
		logic irq;
	} urx_state_s;
endpackage

/* logic/urx_unused_placeholder_removed.sv */
`timescale 1ns/1ps

/* tb/urx_peer.sv */
/*
 * Far-end serial equipment: sends frames on the receive line and captures
 * frames from the transmit line.
 * Assumes the testbench calls its tasks just after a rising clock edge.
 */
`timescale 1ns/1ps

module urx_peer (
	input wire logic i_clock,
	input wire logic i_tx_pin,
	output logic o_line
);
	int bit_clks = 16;

	initial o_line = 1'b1;

	// A bad stop bit goes high again before bit end, so no false start.
	task automatic send(input logic [8:0] w, input int n, input logic stop,
		input logic glitch);
		logic v;
		for (int k = 0; k < n + 2; k++) begin
			v = (k == 0) ? 1'b0 : (k > n) ? stop : w[k-1];
			for (int c = 0; c < bit_clks; c++) begin
				@(posedge i_clock);
				if (k > n && c >= bit_clks - 5) begin
					o_line <= 1'b1;
				end else begin
					o_line <= (glitch && k == 1 && c == 8) ? ~v : v;
				end
			end
		end
		@(posedge i_clock);
		o_line <= 1'b1;
	endtask

	task automatic capture(output logic [8:0] w, input int n);
		int t;
		t = 0;
		w = '0;
		do begin
			@(posedge i_clock);
			t++;
		end while (i_tx_pin !== 1'b0 && t < 4000);
		repeat (bit_clks / 2) @(posedge i_clock);
		for (int i = 0; i <= n; i++) begin
			repeat (bit_clks) @(posedge i_clock);
			w[i] = i_tx_pin;
		end
	endtask
endmodule

/* tb/tb.sv */
/*
 * Self-checking testbench of the serial block.
 * Assumes the register map of urx_defs.svh and one bus wait state.
 */
`timescale 1ns/1ps
`include "urx_defs.svh"

module tb;
	import urx_pkg::*;

	logic i_clock;
	logic i_resetn;
	urx_avs_s avs;
	logic [31:0] rdata;
	logic waitreq, tx_pin, tx_oe, cpu_mask, irq, rx_line;
	logic halt;
	int err_total;
	int comparisons;
	int cycles;
	logic [7:0] q;
	logic [8:0] w;

	urx_serial DUT (
		.i_clock(i_clock),
		.i_resetn(i_resetn),
		.i_avs(avs),
		.o_avs_readdata(rdata),
		.o_avs_waitrequest(waitreq),
		.i_serial_in_pin(rx_line),
		.o_tx_pin(tx_pin),
		.o_tx_oe(tx_oe),
		.i_cpu_irq_mask(cpu_mask),
		.i_halt(halt),
		.o_irq(irq)
	);

	urx_peer peer (.i_clock(i_clock), .i_tx_pin(tx_pin), .o_line(rx_line));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [8:0] seen,
		input logic [8:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic chk1(input string name, input logic s, input logic e);
		check(name, {8'h0, s}, {8'h0, e});
	endtask

	// The request stands until a rising edge samples waitrequest low.
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] r);
		int n;
		n = 0;
		@(posedge i_clock);
		avs.address <= a;
		avs.write <= wr;
		avs.read <= ~wr;
		avs.writedata <= {24'h0, d};
		avs.byteenable <= 4'hf;
		do begin
			@(posedge i_clock);
			n++;
		end while (waitreq !== 1'b0 && n < 100);
		r = rdata[7:0];
		avs.read <= 1'b0;
		avs.write <= 1'b0;
		if (n >= 100) chk1("waitrequest", 1'b1, 1'b0);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		bus(1'b1, a, d, r);
	endtask

	task automatic rd_chk(input string name, input logic [7:0] a,
		input logic [7:0] e);
		logic [7:0] r;
		bus(1'b0, a, 8'h0, r);
		check(name, {1'b0, r}, {1'b0, e});
	endtask

	task automatic flush();
		repeat (300) @(posedge i_clock);
		bus(1'b0, `URX_OFS_STATUS, 8'h0, q);
		bus(1'b0, `URX_OFS_DATA, 8'h0, q);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		rd_chk("status reset", `URX_OFS_STATUS, `URX_STATUS_RESET);
		rd_chk("ctrl2 reset", `URX_OFS_CTRL2, 8'h00);
		rd_chk("unmapped", 8'h20, 8'h00);
		chk1("tx pin reset", tx_pin, 1'b1);
		chk1("irq reset", irq, 1'b0);
	endtask

	task automatic t_halt();
		int n;
		n = 0;
		halt <= 1'b1;
		@(posedge i_clock);
		avs.address <= `URX_OFS_STATUS;
		avs.read <= 1'b1;
		repeat (3) @(posedge i_clock);
		chk1("halt stall", waitreq, 1'b1);
		chk1("halt tx line", tx_pin, 1'b1);
		halt <= 1'b0;
		do begin
			@(posedge i_clock);
			n++;
		end while (waitreq !== 1'b0 && n < 100);
		q = rdata[7:0];
		avs.read <= 1'b0;
		check("halt read", {1'b0, q}, {1'b0, `URX_STATUS_RESET});
	endtask

	task automatic t_rx_idle();
		wr(`URX_OFS_CTRL2, 8'h34);
		peer.send(9'h05a, 8, 1'b1, 1'b0);
		repeat (20) @(posedge i_clock);
		rd_chk("status full", `URX_OFS_STATUS, 8'he0);
		chk1("irq full", irq, 1'b1);
		rd_chk("data", `URX_OFS_DATA, 8'h5a);
		rd_chk("status cleared", `URX_OFS_STATUS, 8'hc0);
		repeat (250) @(posedge i_clock);
		rd_chk("status idle", `URX_OFS_STATUS, 8'hd0);
		chk1("irq idle", irq, 1'b1);
		cpu_mask <= 1'b1;
		repeat (3) @(posedge i_clock);
		chk1("irq masked", irq, 1'b0);
		cpu_mask <= 1'b0;
		bus(1'b0, `URX_OFS_DATA, 8'h0, q);
		repeat (250) @(posedge i_clock);
		rd_chk("idle not again", `URX_OFS_STATUS, 8'hc0);
	endtask

	task automatic t_overrun();
		peer.send(9'h011, 8, 1'b1, 1'b0);
		peer.send(9'h022, 8, 1'b1, 1'b0);
		repeat (20) @(posedge i_clock);
		rd_chk("status overrun", `URX_OFS_STATUS, 8'he8);
		chk1("irq overrun", irq, 1'b1);
		rd_chk("data kept", `URX_OFS_DATA, 8'h11);
		rd_chk("overrun cleared", `URX_OFS_STATUS, 8'hc0);
		flush();
	endtask

	task automatic t_errors();
		peer.send(9'h00f, 8, 1'b0, 1'b0);
		repeat (20) @(posedge i_clock);
		rd_chk("status framing", `URX_OFS_STATUS, 8'he2);
		rd_chk("data framing", `URX_OFS_DATA, 8'h0f);
		peer.send(9'h03c, 8, 1'b1, 1'b1);
		repeat (20) @(posedge i_clock);
		rd_chk("status noise", `URX_OFS_STATUS, 8'he4);
		rd_chk("data noise", `URX_OFS_DATA, 8'h3c);
		flush();
	endtask

	task automatic t_parity_rx();
		wr(`URX_OFS_CTRL1, 8'h05);
		wr(`URX_OFS_CTRL2, 8'h04);
		peer.send(9'h0b5, 8, 1'b1, 1'b0);
		repeat (20) @(posedge i_clock);
		rd_chk("status parity bad", `URX_OFS_STATUS, 8'he1);
		chk1("irq parity", irq, 1'b1);
		bus(1'b0, `URX_OFS_DATA, 8'h0, q);
		peer.send(9'h035, 8, 1'b1, 1'b0);
		repeat (20) @(posedge i_clock);
		rd_chk("status parity good", `URX_OFS_STATUS, 8'he0);
		flush();
	endtask

	task automatic t_mute();
		wr(`URX_OFS_CTRL1, 8'h08);
		wr(`URX_OFS_CTRL2, 8'h26);
		peer.send(9'h012, 8, 1'b1, 1'b0);
		repeat (20) @(posedge i_clock);
		rd_chk("status muted", `URX_OFS_STATUS, 8'hc0);
		chk1("irq muted", irq, 1'b0);
		rd_chk("still muted", `URX_OFS_CTRL2, 8'h26);
		peer.send(9'h093, 8, 1'b1, 1'b0);
		repeat (20) @(posedge i_clock);
		rd_chk("status woken", `URX_OFS_STATUS, 8'he0);
		rd_chk("mute cleared", `URX_OFS_CTRL2, 8'h24);
		rd_chk("address word", `URX_OFS_DATA, 8'h93);
		wr(`URX_OFS_CTRL1, 8'h00);
		wr(`URX_OFS_CTRL2, 8'h26);
		repeat (200) @(posedge i_clock);
		rd_chk("idle woken", `URX_OFS_CTRL2, 8'h24);
		rd_chk("idle wake no flag", `URX_OFS_STATUS, 8'hc0);
		flush();
	endtask

	// Prescale 13 and receive divider 2 give 416 clocks a bit.
	task automatic t_baud();
		wr(`URX_OFS_CTRL2, 8'h00);
		wr(`URX_OFS_BAUD, 8'hc1);
		wr(`URX_OFS_CTRL2, 8'h04);
		peer.bit_clks = 416;
		peer.send(9'h0a7, 8, 1'b1, 1'b0);
		repeat (20) @(posedge i_clock);
		rd_chk("status slow", `URX_OFS_STATUS, 8'he0);
		rd_chk("data slow", `URX_OFS_DATA, 8'ha7);
		wr(`URX_OFS_CTRL2, 8'h00);
		wr(`URX_OFS_BAUD, 8'h00);
		peer.bit_clks = 16;
		flush();
	endtask

	// Odd parity over 7 bits of 8'h35 puts a one in the MSB place.
	task automatic t_tx();
		wr(`URX_OFS_CTRL1, 8'h06);
		wr(`URX_OFS_CTRL2, 8'h48);
		@(posedge i_clock);
		chk1("tx enable", tx_oe, 1'b1);
		bus(1'b0, `URX_OFS_STATUS, 8'h0, q);
		wr(`URX_OFS_DATA, 8'h35);
		peer.capture(w, 8);
		check("tx frame", w, 9'h1b5);
		repeat (40) @(posedge i_clock);
		rd_chk("status tx done", `URX_OFS_STATUS, 8'hc0);
		chk1("irq tx done", irq, 1'b1);
	endtask

	// ------------------------------------------------------------
	// Clock, timeout and main sequence
	// ------------------------------------------------------------
	initial begin
		i_clock = 1'b0;
		forever #2 i_clock = ~i_clock;
	end

	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 60000) begin
			err_total++;
			conclude();
		end
	end

	initial begin
		avs = '0;
		cpu_mask = 1'b0;
		halt = 1'b0;
		i_resetn = 1'b0;
		err_total = 0;
		comparisons = 0;
		cycles = 0;
		repeat (3) @(posedge i_clock);
		i_resetn <= 1'b1;
		t_reset();
		t_halt();
		t_rx_idle();
		t_overrun();
		t_errors();
		t_parity_rx();
		t_mute();
		t_baud();
		t_tx();
		conclude();
	end
endmodule
